// ===== hdl/apsw_params.svh
// Timing constants, wake flag positions and policy reset values for the power-state controller.
// Assumes inclusion by the package, the design modules and the assertion checker only.
`ifndef APSW_PARAMS_SVH
`define APSW_PARAMS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define APSW_CLK_HZ 20000000
`define APSW_LONG_PRESS_MS 4000
`define APSW_LONG_PRESS_CYC ((`APSW_CLK_HZ / 1000) * `APSW_LONG_PRESS_MS)
`define APSW_DEBOUNCE_US 10000
`define APSW_DEBOUNCE_CYC ((`APSW_CLK_HZ / 1000000) * `APSW_DEBOUNCE_US)

// ----------------------------------------------------------------
// Settings reset values
// ----------------------------------------------------------------
`define APSW_S5_WAKE_RST 1'b0
`define APSW_PME_EN_RST 1'b0

// ----------------------------------------------------------------
// Wake flag positions
// ----------------------------------------------------------------
`define APSW_WK_LAN 0
`define APSW_WK_MODEM 1
`define APSW_WK_PME 2
`define APSW_WK_SWITCH 3
`define APSW_WK_PS2 4
`define APSW_WK_RTC 5
`define APSW_WK_USB 6
`define APSW_WK_WAKEPIN 7
`define APSW_WK_N 8

`endif

// ===== hdl/apsw_pkg.sv
// Types shared by the power-state controller and its switch timer.
// Assumes apsw_params.svh is on the include path.
`include "apsw_params.svh"

package apsw_pkg;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        APSW_ST_S0,
        APSW_ST_S1,
        APSW_ST_S3,
        APSW_ST_S4,
        APSW_ST_S5,
        APSW_ST_BOOT
    } apsw_state_t;

    typedef struct packed {
        logic wakepin;
        logic usb;
        logic rtc;
        logic ps2;
        logic power_switch;
        logic pme;
        logic modem;
        logic lan;
    } apsw_wake_t;

    typedef struct packed {
        logic short_press;
        logic long_press;
    } apsw_press_t;

    typedef struct packed {
        logic req_s1;
        logic req_s3;
        logic req_s4;
        logic req_s5;
    } apsw_os_req_t;

endpackage : apsw_pkg

// ===== hdl/apsw_power_ctrl.sv
// Power-state controller: working, sleep and soft-off states, switches and wake sources.
// Assumes standby clock core_clk, pins asynchronous, OS requests on core_clk.
`include "apsw_params.svh"
module apsw_sync2
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic d,
    output logic q
);
    logic meta_reg;
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta_reg <= 1'b0;
            q <= 1'b0;
        end
        else if (clk_en)
        begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule : apsw_sync2

// Functional notes
// - From soft-off, a press under four seconds powers the system on.
// - From working, a press under four seconds enters sleep.
// - From working, a press over four seconds forces soft-off.
// - From sleep, short press wakes; long press forces soft-off.
// - Modem, PS/2 and USB wake only from S1 or S3.
// - Switch, RTC, wake pin, LAN and PME wake from S1, S3, S4, S5.
// - LAN and PME wake from S5 need a setting that resets disabled.
// - With that setting enabled, LAN wake in S5 starts the system.
// - Leaving S5 always runs a full cold boot.
// - An OS soft-off command removes power and enters S5.
// - In S0, a short power press and any sleep switch press both enter S3.
// - Fans run in S0 and S1 only.
// - After AC loss, restore prior state as the policy allows.
module apsw_power_ctrl
    import apsw_pkg::*;
#(
    parameter int unsigned DEBOUNCE_CYC = `APSW_DEBOUNCE_CYC,
    parameter int unsigned LONG_CYC = `APSW_LONG_PRESS_CYC,
    parameter int unsigned BOOT_CYC = 16
)
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic pwr_sw_n,
    input wire logic sleep_sw_n,
    input wire logic [`APSW_WK_N-1:0] wake_pins,
    input apsw_os_req_t os_req,
    input wire logic s5_wake_en,
    input wire logic pme_wake_en,
    input wire logic restore_on_en,
    input wire logic last_state_on,
    input wire logic [`APSW_WK_N-1:0] wake_clr,
    output logic main_pwr_on,
    output logic cold_boot,
    output logic fan_on,
    output logic sleep_req,
    output apsw_state_t state,
    output apsw_wake_t wake_flags
);

    localparam int BW = $clog2(BOOT_CYC + 1);

    apsw_state_t state_reg;
    apsw_state_t state_next;
    logic [`APSW_WK_N-1:0] flag_reg;
    logic [BW-1:0] boot_cnt_reg;
    logic restore_done_reg;
    logic pwr_sync;
    logic sleep_sync;
    logic sleep_sync_d_reg;
    logic [`APSW_WK_N-1:0] wake_sync;
    apsw_press_t pwr_press;
    apsw_press_t slp_press;

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    apsw_sync2 u_sync_pwr (.core_clk(core_clk), .arst_n(arst_n), .clk_en(clk_en),
        .d(!pwr_sw_n), .q(pwr_sync));
    apsw_sync2 u_sync_slp (.core_clk(core_clk), .arst_n(arst_n), .clk_en(clk_en),
        .d(!sleep_sw_n), .q(sleep_sync));
    for (genvar i = 0; i < `APSW_WK_N; i++)
    begin : g_wsync
        apsw_sync2 u_sync_wk (.core_clk(core_clk), .arst_n(arst_n), .clk_en(clk_en),
            .d(wake_pins[i]), .q(wake_sync[i]));
    end

    apsw_switch_timer #(.DEBOUNCE_CYC(DEBOUNCE_CYC), .LONG_CYC(LONG_CYC)) u_pwr_timer
    (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .sw_level(pwr_sync),
        .press(pwr_press)
    );

    apsw_switch_timer #(.DEBOUNCE_CYC(DEBOUNCE_CYC), .LONG_CYC(LONG_CYC)) u_slp_timer
    (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .sw_level(sleep_sync),
        .press(slp_press)
    );

    // ----------------------------------------------------------------
    // Wake qualification
    // ----------------------------------------------------------------
    wire in_light = (state_reg == APSW_ST_S1) || (state_reg == APSW_ST_S3);
    wire in_deep = (state_reg == APSW_ST_S4) || (state_reg == APSW_ST_S5);
    wire asleep = in_light || in_deep;
    wire s5_gate = (state_reg != APSW_ST_S5) || s5_wake_en;
    wire lan_ok = asleep && s5_gate;
    wire pme_ok = asleep && s5_gate && pme_wake_en;
    wire [`APSW_WK_N-1:0] wake_ok;
    assign wake_ok[`APSW_WK_LAN] = lan_ok && wake_sync[`APSW_WK_LAN];
    assign wake_ok[`APSW_WK_PME] = pme_ok && wake_sync[`APSW_WK_PME];
    assign wake_ok[`APSW_WK_MODEM] = in_light && wake_sync[`APSW_WK_MODEM];
    assign wake_ok[`APSW_WK_PS2] = in_light && wake_sync[`APSW_WK_PS2];
    assign wake_ok[`APSW_WK_USB] = in_light && wake_sync[`APSW_WK_USB];
    assign wake_ok[`APSW_WK_RTC] = asleep && wake_sync[`APSW_WK_RTC];
    assign wake_ok[`APSW_WK_WAKEPIN] = asleep && wake_sync[`APSW_WK_WAKEPIN];
    assign wake_ok[`APSW_WK_SWITCH] = asleep && pwr_press.short_press;
    wire any_wake = |wake_ok;
    wire slp_edge = slp_press.short_press || slp_press.long_press;

    // ----------------------------------------------------------------
    // State transitions
    // ----------------------------------------------------------------
    // Long press outranks everything so the forced off cannot be vetoed by software
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            APSW_ST_S0:
            begin
                if (pwr_press.long_press)
                    state_next = APSW_ST_S5;
                else if (os_req.req_s5)
                    state_next = APSW_ST_S5;
                else if (pwr_press.short_press || slp_edge)
                    state_next = APSW_ST_S3;
                else if (os_req.req_s4)
                    state_next = APSW_ST_S4;
                else if (os_req.req_s3)
                    state_next = APSW_ST_S3;
                else if (os_req.req_s1)
                    state_next = APSW_ST_S1;
            end
            APSW_ST_S1, APSW_ST_S3, APSW_ST_S4:
            begin
                if (pwr_press.long_press)
                    state_next = APSW_ST_S5;
                else if (os_req.req_s5)
                    state_next = APSW_ST_S5;
                else if (any_wake)
                    state_next = APSW_ST_S0;
            end
            APSW_ST_S5:
            begin
                if (any_wake)
                    state_next = APSW_ST_BOOT;
                else if (!restore_done_reg && restore_on_en && last_state_on)
                    state_next = APSW_ST_BOOT;
            end
            APSW_ST_BOOT:
            begin
                if (pwr_press.long_press)
                    state_next = APSW_ST_S5;
                else if (boot_cnt_reg == BW'(BOOT_CYC))
                    state_next = APSW_ST_S0;
            end
            default:
                state_next = APSW_ST_S5;
        endcase
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_reg <= APSW_ST_S5;
            boot_cnt_reg <= '0;
            restore_done_reg <= 1'b0;
            sleep_sync_d_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            state_reg <= state_next;
            restore_done_reg <= 1'b1;
            sleep_sync_d_reg <= slp_edge;
            boot_cnt_reg <= (state_reg == APSW_ST_BOOT) ? boot_cnt_reg + 1'b1 : '0;
        end
    end

    // Set wins over a clear in the same cycle so no wake cause is lost
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            flag_reg <= '0;
        else if (clk_en)
            flag_reg <= (flag_reg & ~wake_clr) | wake_ok;
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign state = state_reg;
    assign wake_flags = flag_reg;
    assign main_pwr_on = (state_reg == APSW_ST_S0) || (state_reg == APSW_ST_S1)
        || (state_reg == APSW_ST_BOOT);
    assign cold_boot = (state_reg == APSW_ST_BOOT);
    assign fan_on = (state_reg == APSW_ST_S0) || (state_reg == APSW_ST_S1);
    assign sleep_req = sleep_sync_d_reg && (state_reg == APSW_ST_S3);

endmodule : apsw_power_ctrl

// ===== hdl/apsw_switch_timer.sv
// Debounces one synchronised switch level and classifies each press by duration.
// Assumes the input is already synchronised to core_clk.
`include "apsw_params.svh"
module apsw_switch_timer
    import apsw_pkg::*;
#(
    parameter int unsigned DEBOUNCE_CYC = `APSW_DEBOUNCE_CYC,
    parameter int unsigned LONG_CYC = `APSW_LONG_PRESS_CYC
)
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic sw_level,
    output apsw_press_t press
);

    localparam int CW = $clog2(LONG_CYC + 1);
    localparam int DW = $clog2(DEBOUNCE_CYC + 1);

    logic stable_reg;
    logic [DW-1:0] db_cnt_reg;
    logic [CW-1:0] hold_cnt_reg;
    logic long_done_reg;
    apsw_press_t press_reg;

    // ----------------------------------------------------------------
    // Debounce and hold timing
    // ----------------------------------------------------------------
    wire differ = (sw_level != stable_reg);
    wire db_done = (db_cnt_reg == DW'(DEBOUNCE_CYC));
    wire hold_full = (hold_cnt_reg == CW'(LONG_CYC));
    wire released = differ && db_done && stable_reg;

    assign press = press_reg;

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            stable_reg <= 1'b0;
            db_cnt_reg <= '0;
            hold_cnt_reg <= '0;
            long_done_reg <= 1'b0;
            press_reg <= '0;
        end
        else if (clk_en)
        begin
            press_reg <= '0;
            db_cnt_reg <= differ ? (db_done ? '0 : db_cnt_reg + 1'b1) : '0;
            if (differ && db_done)
                stable_reg <= sw_level;
            if (stable_reg && !hold_full)
                hold_cnt_reg <= hold_cnt_reg + 1'b1;
            if (stable_reg && hold_full && !long_done_reg)
            begin
                // Long press fires while still held: a forced off never waits for release
                press_reg.long_press <= 1'b1;
                long_done_reg <= 1'b1;
            end
            if (released)
            begin
                press_reg.short_press <= !long_done_reg;
                hold_cnt_reg <= '0;
                long_done_reg <= 1'b0;
            end
        end
    end

endmodule : apsw_switch_timer

// ===== verification/acpi_power_state_and_wake_control_tb_top.sv
// Self-checking bench for the power-state controller with shortened timing.
// Assumes the package, checker and switch model are compiled first.
module acpi_power_state_and_wake_control_tb_top
    import apsw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic clk_en = 1'b1;
    logic pwr_sw_n;
    logic sleep_sw_n;
    logic [7:0] wake_pins;
    apsw_os_req_t os_req = '0;
    logic s5_wake_en = 1'b0;
    logic pme_wake_en = 1'b1;
    logic restore_on_en = 1'b0;
    logic last_state_on = 1'b0;
    logic [7:0] wake_clr = 8'h00;
    logic main_pwr_on;
    logic cold_boot;
    logic fan_on;
    logic sleep_req;
    apsw_state_t state;
    apsw_wake_t wake_flags;
    logic sleep_seen = 1'b0;
    int n_fail = 0;
    int cmp_count = 0;
    int cyc = 0;
    always #25 core_clk = ~core_clk;
    apsw_front_model fm_u (.core_clk(core_clk), .pwr_sw_n(pwr_sw_n), .sleep_sw_n(sleep_sw_n),
        .wake_pins(wake_pins));
    apsw_power_ctrl #(.DEBOUNCE_CYC(4), .LONG_CYC(40), .BOOT_CYC(4)) dut_u (
        .core_clk(core_clk), .arst_n(arst_n), .clk_en(clk_en), .pwr_sw_n(pwr_sw_n),
        .sleep_sw_n(sleep_sw_n), .wake_pins(wake_pins), .os_req(os_req),
        .s5_wake_en(s5_wake_en), .pme_wake_en(pme_wake_en), .restore_on_en(restore_on_en),
        .last_state_on(last_state_on), .wake_clr(wake_clr), .main_pwr_on(main_pwr_on),
        .cold_boot(cold_boot), .fan_on(fan_on), .sleep_req(sleep_req), .state(state),
        .wake_flags(wake_flags));
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : summarize
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Bounded wait, so a stuck state machine shows up as a mismatch
    task automatic reach(input apsw_state_t s);
        int i;
        i = 0;
        while (state !== s && i < 300)
        begin
            @(negedge core_clk);
            i++;
        end
        check(8'(state), 8'(s));
    endtask : reach
    task automatic os_cmd(input apsw_os_req_t r);
        @(negedge core_clk);
        os_req = r;
        @(negedge core_clk);
        os_req = '0;
    endtask : os_cmd
    task automatic clear_flags;
        @(negedge core_clk);
        wake_clr = 8'hff;
        @(negedge core_clk);
        wake_clr = 8'h00;
        @(negedge core_clk);
        check(8'(wake_flags), 8'h00);
    endtask : clear_flags
    task automatic t_switch;
        fm_u.press(1'b0, 15);
        reach(APSW_ST_BOOT);
        check({7'h00, cold_boot}, 8'h01);
        reach(APSW_ST_S0);
        check({7'h00, fan_on}, 8'h01);
        fm_u.press(1'b0, 15);
        reach(APSW_ST_S3);
        check({7'h00, fan_on}, 8'h00);
        fm_u.press(1'b0, 15);
        reach(APSW_ST_S0);
        fm_u.press(1'b0, 60);
        reach(APSW_ST_S5);
    endtask : t_switch
    task automatic t_os;
        fm_u.press(1'b0, 15);
        reach(APSW_ST_S0);
        os_cmd(4'b0100);
        reach(APSW_ST_S3);
        fm_u.press(1'b0, 60);
        reach(APSW_ST_S5);
        fm_u.press(1'b0, 15);
        reach(APSW_ST_S0);
        fm_u.press(1'b1, 15);
        reach(APSW_ST_S3);
        repeat (3) @(negedge core_clk);
        check({7'h00, sleep_seen}, 8'h01);
        fm_u.press(1'b0, 15);
        reach(APSW_ST_S0);
        os_cmd(4'b0001);
        reach(APSW_ST_S5);
        check({7'h00, main_pwr_on}, 8'h00);
    endtask : t_os
    task automatic t_wake;
        clear_flags();
        fm_u.wake(0, 1'b1);
        repeat (20) @(negedge core_clk);
        check(8'(state), 8'(APSW_ST_S5));
        check(8'(wake_flags), 8'h00);
        s5_wake_en = 1'b1;
        reach(APSW_ST_S0);
        check(8'(wake_flags), 8'h01);
        fm_u.wake(0, 1'b0);
        clear_flags();
        os_cmd(4'b0010);
        reach(APSW_ST_S4);
        fm_u.wake(1, 1'b1);
        repeat (20) @(negedge core_clk);
        check(8'(state), 8'(APSW_ST_S4));
        fm_u.wake(5, 1'b1);
        reach(APSW_ST_S0);
        check(8'(wake_flags), 8'h20);
        fm_u.wake(5, 1'b0);
        os_cmd(4'b0100);
        reach(APSW_ST_S0);
        check(8'(wake_flags), 8'h22);
        fm_u.wake(1, 1'b0);
        clear_flags();
        os_cmd(4'b0001);
        reach(APSW_ST_S5);
        s5_wake_en = 1'b0;
        fm_u.wake(2, 1'b1);
        repeat (20) @(negedge core_clk);
        check(8'(state), 8'(APSW_ST_S5));
        s5_wake_en = 1'b1;
        reach(APSW_ST_S0);
        check(8'(wake_flags), 8'h04);
        fm_u.wake(2, 1'b0);
        clear_flags();
    endtask : t_wake
    task automatic t_restore;
        restore_on_en = 1'b1;
        last_state_on = 1'b1;
        arst_n = 1'b0;
        repeat (3) @(negedge core_clk);
        arst_n = 1'b1;
        reach(APSW_ST_BOOT);
        reach(APSW_ST_S0);
    endtask : t_restore
    initial
    begin
        repeat (16) @(negedge core_clk);
        arst_n = 1'b1;
        reach(APSW_ST_S5);
        t_switch();
        t_os();
        t_wake();
        t_restore();
        summarize();
    end
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (sleep_req === 1'b1)
            sleep_seen <= 1'b1;
        if (cyc == 5000)
        begin
            n_fail++;
            summarize();
        end
    end
endmodule : acpi_power_state_and_wake_control_tb_top
bind apsw_power_ctrl apsw_power_ctrl_asserts #(.BOOT_CYC(BOOT_CYC)) chk_u (
    .core_clk(core_clk), .arst_n(arst_n), .clk_en(clk_en), .os_req(os_req),
    .s5_wake_en(s5_wake_en), .wake_clr(wake_clr), .main_pwr_on(main_pwr_on),
    .cold_boot(cold_boot), .fan_on(fan_on), .sleep_req(sleep_req), .state(state),
    .wake_flags(wake_flags));

// ===== verification/apsw_front_model.sv
// Front panel switches and wake sources facing the power-state controller.
// Assumes the bench calls its tasks; switch contacts have pull-ups.
module apsw_front_model
(
    input wire logic core_clk,
    output logic pwr_sw_n,
    output logic sleep_sw_n,
    output logic [7:0] wake_pins
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        pwr_sw_n = 1'b1;
        sleep_sw_n = 1'b1;
        wake_pins = 8'h00;
    end
    // Hold length sets short or long press, so the same task serves both
    task automatic press(input bit sleep_key, input int n);
        // Rest first, so the previous release clears synchroniser and debounce
        repeat (12) @(negedge core_clk);
        pwr_sw_n = sleep_key;
        sleep_sw_n = !sleep_key;
        repeat (n) @(negedge core_clk);
        pwr_sw_n = 1'b1;
        sleep_sw_n = 1'b1;
    endtask : press
    task automatic wake(input int b, input logic v);
        @(negedge core_clk);
        wake_pins[b] = v;
    endtask : wake
endmodule : apsw_front_model

// ===== verification/apsw_power_ctrl_asserts.sv
// Port-level checks for the power-state controller.
// Assumes it is bound into apsw_power_ctrl and given the same BOOT_CYC.
`include "apsw_params.svh"
module apsw_power_ctrl_asserts
    import apsw_pkg::*;
#(
    parameter int unsigned BOOT_CYC = 16
)
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input apsw_os_req_t os_req,
    input wire logic s5_wake_en,
    input wire logic [`APSW_WK_N-1:0] wake_clr,
    input wire logic main_pwr_on,
    input wire logic cold_boot,
    input wire logic fan_on,
    input wire logic sleep_req,
    input apsw_state_t state,
    input apsw_wake_t wake_flags
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    // ----------------------------------------
    // Boot length counter
    // ----------------------------------------
    // Counts enabled cycles only, since a frozen clock enable also freezes the state
    logic [7:0] boot_len_reg;
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            boot_len_reg <= 8'h00;
        else if (state != APSW_ST_BOOT)
            boot_len_reg <= 8'h00;
        else if (clk_en)
            boot_len_reg <= boot_len_reg + 8'h01;
    end
    AST_FAN: assert property (fan_on == (state inside {APSW_ST_S0, APSW_ST_S1}))
        else $error("fan output disagrees with state");
    AST_PWR: assert property (main_pwr_on == (state inside {APSW_ST_S0, APSW_ST_S1,
        APSW_ST_BOOT}) && cold_boot == (state == APSW_ST_BOOT))
        else $error("power outputs disagree with state");
    AST_OS_OFF: assert property (clk_en && state == APSW_ST_S0 && os_req.req_s5
        |=> state == APSW_ST_S5) else $error("soft-off command not taken");
    AST_S5_EXIT: assert property ($past(state) == APSW_ST_S5 && state != APSW_ST_S5
        |-> state == APSW_ST_BOOT) else $error("soft-off left without cold boot");
    AST_BOOT_LEN: assert property ($past(state) == APSW_ST_BOOT && state == APSW_ST_S0
        |-> 32'(boot_len_reg) == BOOT_CYC + 1) else $error("cold boot length wrong");
    AST_GATE: assert property ($rose(wake_flags.modem) || $rose(wake_flags.ps2)
        || $rose(wake_flags.usb) |-> $past(state) inside {APSW_ST_S1, APSW_ST_S3})
        else $error("modem, keyboard or usb wake outside S1 and S3");
    AST_WAKE: assert property ($rose(wake_flags.rtc)
        && $past(state) inside {APSW_ST_S1, APSW_ST_S3, APSW_ST_S4}
        |-> state == APSW_ST_S0) else $error("alarm wake did not resume");
    AST_LAN_S5: assert property ($rose(wake_flags.lan) && $past(state) == APSW_ST_S5
        |-> $past(s5_wake_en) && state == APSW_ST_BOOT) else $error("network wake from S5 wrong");
    AST_SLEEP: assert property (sleep_req |-> state == APSW_ST_S3 ##1 !sleep_req)
        else $error("sleep request outside S3 or too long");
    AST_STICKY: assert property (((~8'(wake_flags)) & $past(8'(wake_flags))
        & ~$past(wake_clr)) == 8'h00) else $error("wake flag dropped without clear");
endmodule : apsw_power_ctrl_asserts
